/* design/tfsc_flags.sv */
// Flag, status and counter-clear control register with capture registers of a 16-bit timer.
`timescale 1ns/1ps
// Function
// RQ1: Writing zero clears flags; writing one ignored.
// RQ2: Reset or standby forces register to zero.
// RQ3: Processor reads flag set, then writes zero.
// RQ4: Only hardware events set any flag.
// RQ5: Unbuffered A edge captures counter, sets flag.
// RQ6: Buffered A shifts A into C first.
// RQ7: B edge captures, buffered shifts into D.
// RQ8: C edge captures into C, sets flag.
// RQ9: Buffered A: C edge only sets flag.
// RQ10: D edge captures into D, sets flag.
// RQ11: Buffered B: D edge only sets flag.
// RQ12: Counter equals compare A sets flag.
// RQ13: Counter equals compare B sets flag.
// RQ14: Counter wrapping to zero sets flag.
// RQ15: Clear bit resets counter at match A.
// RQ16: Request raised only when enable set.
// RQ17: Edge select zero falling, one rising.
// RQ18: Set event beats same-cycle clear.
module tfsc_flags (
  input  wire logic        clk_sys,                  // System clock, 40 MHz.
  input  wire logic        reset,                    // Synchronous reset, active high.
  input  wire logic        standby_enter,            // High while a standby mode is entered.
  input  wire logic        reg_rd,                   // Read strobe of the flag register.
  input  wire logic        reg_wr,                   // Write strobe of the flag register.
  input  wire logic [7:0]  reg_wdata,                // Write data.
  output logic      [7:0]  reg_rdata,                // Read data, registered.
  input  wire logic [15:0] free_running_counter,     // Current counter value.
  input  wire logic [15:0] compare_register_a,       // Compare value A.
  input  wire logic [15:0] compare_register_b,       // Compare value B.
  input  wire logic        capture_input_a,          // Capture pin A.
  input  wire logic        capture_input_b,          // Capture pin B.
  input  wire logic        capture_input_c,          // Capture pin C.
  input  wire logic        capture_input_d,          // Capture pin D.
  input  wire logic        edge_select_a,            // Edge of pin A: 1 rising.
  input  wire logic        edge_select_b,            // Edge of pin B: 1 rising.
  input  wire logic        edge_select_c,            // Edge of pin C: 1 rising.
  input  wire logic        edge_select_d,            // Edge of pin D: 1 rising.
  input  wire logic        buffer_enable_chan_a,     // Register C buffers register A.
  input  wire logic        buffer_enable_chan_b,     // Register D buffers register B.
  input  wire logic [7:1]  irq_enable,               // Enables, same order as flags.
  output logic      [7:1]  irq_request,              // Requests, same order as flags.
  output logic      [15:0] capture_register_a,       // Capture register A.
  output logic      [15:0] capture_register_b,       // Capture register B.
  output logic      [15:0] capture_register_c,       // Capture register C.
  output logic      [15:0] capture_register_d,       // Capture register D.
  output logic             clear_counter_on_match_a, // Control bit level.
  output logic             counter_clear_pulse       // Counter clear request at match A.
);
  logic [7:1] flags_reg;      // The seven event flags.
  logic [7:1] flags_next;     // Next flag value.
  logic [7:1] armed_reg;      // Flags seen as 1 by a read, so a zero write may clear.
  logic       clear_ctl_reg;  // Counter clear control bit.
  logic [7:0] rdata_reg;      // Registered read data.
  logic [15:0] prev_count_reg; // Counter one cycle ago, for wrap detection.
  logic [3:0] rise_w;         // Accepted rises, pins A to D.
  logic [3:0] fall_w;         // Accepted falls, pins A to D.
  logic       evt_a, evt_b, evt_c, evt_d; // Capture events per channel.
  logic       match_a, match_b, wrap_w;   // Counter events.
  logic [7:1] set_vec;        // Hardware set requests.
  logic [7:1] clr_vec;        // Valid software clears.
  logic       hold_zero;      // Reset or standby entry.
  logic [3:0] pins_w;         // Pins gathered for the generate loop.

  // Picks the selected edge of one input.
  function automatic logic pick_edge(input logic rise, input logic fall, input logic sel);
    // RQ17 polarity of selection
    pick_edge = sel ? rise : fall;
  endfunction

  assign pins_w = {capture_input_d, capture_input_c, capture_input_b, capture_input_a};
  assign hold_zero = reset || standby_enter;

  // One synchroniser and edge detector per capture pin.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      tfsc_edge_detect u_edge (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .pin_in     (pins_w[gi]),
        .rise_pulse (rise_w[gi]),
        .fall_pulse (fall_w[gi])
      );
    end
  endgenerate

  // Buffered channels with unequal selects capture on both edges of the main pin.
  assign evt_a = pick_edge(rise_w[0], fall_w[0], edge_select_a) ||
                 (buffer_enable_chan_a && pick_edge(rise_w[0], fall_w[0], edge_select_c));
  assign evt_b = pick_edge(rise_w[1], fall_w[1], edge_select_b) ||
                 (buffer_enable_chan_b && pick_edge(rise_w[1], fall_w[1], edge_select_d));
  assign evt_c = pick_edge(rise_w[2], fall_w[2], edge_select_c);
  assign evt_d = pick_edge(rise_w[3], fall_w[3], edge_select_d);

  // Counter events: equality is a level, so the flag keeps setting while it holds.
  assign match_a = (free_running_counter == compare_register_a);
  assign match_b = (free_running_counter == compare_register_b);
  assign wrap_w  = (prev_count_reg == tfsc_pkg::COUNT_MAX) && (free_running_counter == tfsc_pkg::COUNT_ZERO);

  // Track the previous count for wrap detection.
  always_ff @(posedge clk_sys) begin
    if (hold_zero) begin
      prev_count_reg <= tfsc_pkg::COUNT_ZERO;
    end else begin
      prev_count_reg <= free_running_counter;
    end
  end

  // Gather set requests; nothing the processor does reaches this vector.
  always_comb begin
    set_vec = '0;
    // RQ4 hardware only sets
    set_vec[tfsc_pkg::BIT_CAP_A] = evt_a;
    set_vec[tfsc_pkg::BIT_CAP_B] = evt_b;
    // RQ9 flag C always sets
    set_vec[tfsc_pkg::BIT_CAP_C] = evt_c;
    // RQ11 flag D always sets
    set_vec[tfsc_pkg::BIT_CAP_D] = evt_d;
    // RQ12 compare A match
    set_vec[tfsc_pkg::BIT_CMP_A] = match_a;
    // RQ13 compare B match
    set_vec[tfsc_pkg::BIT_CMP_B] = match_b;
    // RQ14 counter wrap
    set_vec[tfsc_pkg::BIT_WRAP]  = wrap_w;
  end

  // RQ1 zero written clears
  // RQ3 only after read
  assign clr_vec = reg_wr ? (~reg_wdata[7:1] & armed_reg) : '0;

  // RQ18 set wins over clear
  assign flags_next = (flags_reg & ~clr_vec) | set_vec;

  // Flag register; reset and standby both force zero.
  always_ff @(posedge clk_sys) begin
    // RQ2 zero on reset, standby
    if (hold_zero) begin
      flags_reg <= tfsc_pkg::REG_RESET[7:1];
    end else begin
      flags_reg <= flags_next;
    end
  end

  // A read arms each flag that read as 1; a write or a cleared flag disarms it.
  always_ff @(posedge clk_sys) begin
    if (hold_zero) begin
      armed_reg <= '0;
    end else if (reg_rd) begin
      armed_reg <= flags_reg;
    end else if (reg_wr) begin
      armed_reg <= '0;
    end else begin
      armed_reg <= armed_reg & flags_reg;
    end
  end

  // The control bit is plain read/write.
  always_ff @(posedge clk_sys) begin
    if (hold_zero) begin
      clear_ctl_reg <= tfsc_pkg::REG_RESET[tfsc_pkg::BIT_CLR_CTL];
    end else if (reg_wr) begin
      clear_ctl_reg <= reg_wdata[tfsc_pkg::BIT_CLR_CTL];
    end
  end

  // Read data is sampled on the strobe and held until the next read.
  always_ff @(posedge clk_sys) begin
    if (hold_zero) begin
      rdata_reg <= tfsc_pkg::REG_RESET;
    end else if (reg_rd) begin
      rdata_reg <= {flags_reg, clear_ctl_reg};
    end
  end

  // Capture channel A and its buffer C; C captures itself only when not buffering.
  always_ff @(posedge clk_sys) begin
    if (hold_zero) begin
      capture_register_a <= tfsc_pkg::CAPTURE_INIT;
      capture_register_c <= tfsc_pkg::CAPTURE_INIT;
    end else begin
      if (evt_a) begin
        // RQ5 capture counter into A
        capture_register_a <= free_running_counter;
      end
      if (buffer_enable_chan_a) begin
        if (evt_a) begin
          // RQ6 shift A into C
          capture_register_c <= capture_register_a;
        end
      end else if (evt_c) begin
        // RQ8 capture counter into C
        capture_register_c <= free_running_counter;
      end
    end
  end

  // Capture channel B and its buffer D.
  always_ff @(posedge clk_sys) begin
    if (hold_zero) begin
      capture_register_b <= tfsc_pkg::CAPTURE_INIT;
      capture_register_d <= tfsc_pkg::CAPTURE_INIT;
    end else begin
      if (evt_b) begin
        // RQ7 capture B, buffer D
        capture_register_b <= free_running_counter;
      end
      if (buffer_enable_chan_b) begin
        if (evt_b) begin
          capture_register_d <= capture_register_b;
        end
      end else if (evt_d) begin
        // RQ10 capture counter into D
        capture_register_d <= free_running_counter;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign clear_counter_on_match_a = clear_ctl_reg;
  // RQ15 clear counter at match
  assign counter_clear_pulse = clear_ctl_reg && match_a;
  // RQ16 gate requests by enable
  assign irq_request = flags_reg & irq_enable;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || standby_enter);

  // A write never raises a flag, and a set flag written with one stays set.
  write_one_a: assert property (reg_wr && (set_vec == '0) // RQ1 RQ4
      |=> ((flags_reg & ~$past(flags_reg)) == '0)
      && ((flags_reg & $past(reg_wdata[7:1]) & $past(flags_reg)) == ($past(reg_wdata[7:1]) & $past(flags_reg))))
      else $error("write changed a flag wrongly");
  // Standby entry empties the register by the next edge.
  standby_zero_a: assert property (disable iff (reset) $rose(standby_enter) // RQ2
      |=> (flags_reg == '0) && !clear_ctl_reg) else $error("standby did not clear register");
  // Zero write without an earlier read leaves the flag alone.
  clear_unread_a: assert property (reg_wr && !armed_reg[tfsc_pkg::BIT_WRAP] && flags_reg[tfsc_pkg::BIT_WRAP] // RQ3
      |=> flags_reg[tfsc_pkg::BIT_WRAP]) else $error("flag cleared without read");
  // Capture A stores the counter and raises its flag together.
  capture_a_a: assert property (evt_a |=> flags_reg[tfsc_pkg::BIT_CAP_A] // RQ5
      && (capture_register_a == $past(free_running_counter))) else $error("capture A wrong");
  // Buffered capture A moves the old value to C.
  buffer_a_a: assert property (evt_a && buffer_enable_chan_a // RQ6
      |=> capture_register_c == $past(capture_register_a)) else $error("buffer A shift wrong");
  // Buffered capture B moves the old value to D.
  buffer_b_a: assert property (evt_b && buffer_enable_chan_b // RQ7
      |=> (capture_register_d == $past(capture_register_b)) && flags_reg[tfsc_pkg::BIT_CAP_B])
      else $error("buffer B shift wrong");
  // Buffered C edge only flags; register C is left unchanged.
  capture_c_a: assert property (evt_c && !evt_a && buffer_enable_chan_a // RQ9
      |=> $stable(capture_register_c) && flags_reg[tfsc_pkg::BIT_CAP_C]) else $error("C captured while buffered");
  // Unbuffered D edge latches the counter.
  capture_d_a: assert property (evt_d && !buffer_enable_chan_b // RQ10
      |=> capture_register_d == $past(free_running_counter)) else $error("D capture wrong");
  // A compare match held for two cycles has raised flag A by the second cycle.
  compare_a_a: assert property (match_a [*2] |-> flags_reg[tfsc_pkg::BIT_CMP_A]) else $error("compare A flag"); // RQ12
  // Compare match B raises its flag by the next edge.
  compare_b_a: assert property (match_b |=> flags_reg[tfsc_pkg::BIT_CMP_B]) else $error("compare B flag"); // RQ13
  // Wrap from the last count to zero raises the wrap flag.
  wrap_flag_a: assert property ($past(free_running_counter) == tfsc_pkg::COUNT_MAX // RQ14
      && free_running_counter == tfsc_pkg::COUNT_ZERO |=> flags_reg[tfsc_pkg::BIT_WRAP]) else $error("wrap flag");
  // No request leaves while its enable is low.
  irq_gate_a: assert property ((irq_request & ~irq_enable) == '0) else $error("request without enable"); // RQ16
  // A set in the clearing cycle survives, for every flag.
  set_wins_a: assert property ((clr_vec & set_vec) != '0 // RQ18
      |=> (flags_reg & $past(clr_vec) & $past(set_vec)) == ($past(clr_vec) & $past(set_vec)))
      else $error("set lost to clear");
endmodule

/* inc/tfsc_pkg.sv */
// Shared constants for the timer flag, status and clear-control block.
package tfsc_pkg;
  // Bit positions inside the flag and clear-control register.
  localparam int unsigned BIT_CAP_A    = 7;  // Capture flag A.
  localparam int unsigned BIT_CAP_B    = 6;  // Capture flag B.
  localparam int unsigned BIT_CAP_C    = 5;  // Capture flag C.
  localparam int unsigned BIT_CAP_D    = 4;  // Capture flag D.
  localparam int unsigned BIT_CMP_A    = 3;  // Compare flag A.
  localparam int unsigned BIT_CMP_B    = 2;  // Compare flag B.
  localparam int unsigned BIT_WRAP     = 1;  // Counter wrap flag.
  localparam int unsigned BIT_CLR_CTL  = 0;  // Clear counter on match A.
  localparam int unsigned FLAG_LO      = 1;  // Lowest flag bit.
  localparam int unsigned FLAG_HI      = 7;  // Highest flag bit.
  // Values after reset and standby entry.
  localparam logic [7:0]  REG_RESET    = 8'h00;  // Whole register.
  localparam logic [15:0] CAPTURE_INIT = 16'h0000; // Capture registers.
  // Counter end points that mark a wrap.
  localparam logic [15:0] COUNT_MAX    = 16'hffff; // Last count.
  localparam logic [15:0] COUNT_ZERO   = 16'h0000; // Count after wrap.
  // Depth of the capture input synchroniser.
  localparam int unsigned SYNC_STAGES  = 3;  // Flip-flops per input.
endpackage

/* design/tfsc_edge_detect.sv */
// Synchroniser and edge detector for one external capture input.
`timescale 1ns/1ps
module tfsc_edge_detect (
  input  wire logic clk_sys,   // System clock.
  input  wire logic reset,     // Synchronous reset, active high.
  input  wire logic pin_in,    // Asynchronous capture pin level.
  output logic      rise_pulse, // One-cycle pulse on an accepted rise.
  output logic      fall_pulse  // One-cycle pulse on an accepted fall.
);
  logic [tfsc_pkg::SYNC_STAGES-1:0] sync_reg;   // Synchroniser chain.
  logic                             stable_reg; // Last accepted level.

  // Shift the pin through the chain; stage 0 feeds only stage 1.
  // The chain keeps sampling through reset, so it holds the true pin level when reset ends.
  always_ff @(posedge clk_sys) begin
    sync_reg <= {sync_reg[tfsc_pkg::SYNC_STAGES-2:0], pin_in};
  end

  // A new level counts only once stages 1 and 2 agree, which filters glitches.
  // During reset the accepted level follows the pin, so a pin that idles high gives no false edge.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stable_reg <= sync_reg[2];
    end else if (sync_reg[1] == sync_reg[2]) begin
      stable_reg <= sync_reg[2];
    end
  end

  // Edges are the accepted level changing; none is reported while reset is held.
  assign rise_pulse = !reset && (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !stable_reg;
  assign fall_pulse = !reset && (sync_reg[1] == sync_reg[2]) && !sync_reg[2] && stable_reg;
endmodule

/* bench/tfsc_cpu_model.sv */
// Processor-side model that reads and writes the flag register.
`timescale 1ns/1ps
module tfsc_cpu_model (
  input  wire logic       clk_sys,   // System clock.
  output logic            reg_rd,    // Read strobe.
  output logic            reg_wr,    // Write strobe.
  output logic      [7:0] reg_wdata, // Write data.
  input  wire logic [7:0] reg_rdata  // Registered read data.
);
  // Strobes idle low; idle data is the inverse of the last write, so it is never trusted.
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h5a;
  end
  // One read; the data has landed by the falling edge after the taking edge.
  task automatic rd(output logic [7:0] d);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // One write, held across exactly one rising edge.
  task automatic wr(input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic clr(input logic [7:0] d);
    logic [7:0] v;
    rd(v);
    wr(d);
  endtask
endmodule

/* bench/tb_timer_flag_status_control.sv */
// Self-checking testbench of the timer flag, status and clear-control block.
`timescale 1ns/1ps
module tb_timer_flag_status_control;
  logic        clk_sys, reset, standby_enter;        // Clock, reset and standby.
  logic        reg_rd, reg_wr;                       // Bus strobes.
  logic [7:0]  reg_wdata, reg_rdata, v;              // Bus data and read result.
  logic [15:0] cnt, cmp_a, cmp_b;                    // Counter and compare values.
  logic [15:0] cap_a, cap_b, cap_c, cap_d;           // Capture registers.
  logic [3:0]  pins, sel;                            // Pins and edge selects, index 0 is channel A.
  logic        buf_a, buf_b, clr_lvl, clr_pulse;     // Buffer modes and counter clear.
  logic [7:1]  irq_en, irq_req;                      // Enables and requests.
  int          n_fail, tests_run;                    // Mismatches and comparisons.

  tfsc_cpu_model cpu (.clk_sys(clk_sys), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
                      .reg_rdata(reg_rdata));
  tfsc_flags uut (.clk_sys(clk_sys), .reset(reset), .standby_enter(standby_enter), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .free_running_counter(cnt),
    .compare_register_a(cmp_a), .compare_register_b(cmp_b), .capture_input_a(pins[0]),
    .capture_input_b(pins[1]), .capture_input_c(pins[2]), .capture_input_d(pins[3]),
    .edge_select_a(sel[0]), .edge_select_b(sel[1]), .edge_select_c(sel[2]), .edge_select_d(sel[3]),
    .buffer_enable_chan_a(buf_a), .buffer_enable_chan_b(buf_b), .irq_enable(irq_en),
    .irq_request(irq_req), .capture_register_a(cap_a), .capture_register_b(cap_b),
    .capture_register_c(cap_c), .capture_register_d(cap_d), .clear_counter_on_match_a(clr_lvl),
    .counter_clear_pulse(clr_pulse));

  // Clock of 25 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Comparison of values up to 16 bits; case equality so an unknown never matches.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Register read compared with an expected value.
  task automatic rchk(input logic [7:0] exp);
    cpu.rd(v);
    chk("flag register", {8'h00, exp}, {8'h00, v});
  endtask

  // Moves one pin and leaves time for the three-flop synchroniser and the capture edge.
  task automatic pin(input int i, input logic lvl);
    @(negedge clk_sys);
    pins[i] = lvl;
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic t_reset;
    rchk(8'h00);
    chk("capture a", 16'h0000, cap_a);
    chk("capture d", 16'h0000, cap_d);
    $display("test reset done");
  endtask

  task automatic t_wrap;
    irq_en = 7'b0000001;
    @(negedge clk_sys);
    cnt = 16'hffff;
    @(negedge clk_sys);
    cnt = 16'h0000;
    repeat (2) @(negedge clk_sys);
    cnt = 16'h0100;
    rchk(8'h02);
    chk("wrap request", 16'h0001, {9'h000, irq_req});
    irq_en = 7'b0000000;
    #1 chk("masked request", 16'h0000, {9'h000, irq_req});
    cpu.wr(8'hfe);
    cpu.wr(8'h00);
    rchk(8'h02);
    cpu.wr(8'h00);
    rchk(8'h00);
    $display("test wrap done");
  endtask

  task automatic t_compare;
    cpu.wr(8'h01);
    chk("clear control", 16'h0001, {15'h0000, clr_lvl});
    @(negedge clk_sys);
    cmp_a = 16'h0100;
    cmp_b = 16'h0100;
    #1 chk("clear pulse on", 16'h0001, {15'h0000, clr_pulse});
    @(negedge clk_sys);
    cmp_a = 16'h1000;
    cmp_b = 16'h2000;
    rchk(8'h0d);
    cpu.clr(8'h01);
    rchk(8'h01);
    cpu.wr(8'h00);
    @(negedge clk_sys);
    cmp_a = 16'h0100;
    #1 chk("clear pulse off", 16'h0000, {15'h0000, clr_pulse});
    cpu.clr(8'h00);
    rchk(8'h08);
    cmp_a = 16'h1000;
    cpu.clr(8'h00);
    rchk(8'h00);
    $display("test compare done");
  endtask

  task automatic t_capture;
    cnt = 16'h0111;
    pin(0, 1'b1);
    chk("capture a", 16'h0111, cap_a);
    cnt = 16'h0222;
    buf_a = 1'b1;
    pin(0, 1'b0);
    chk("capture a fall", 16'h0111, cap_a);
    pin(0, 1'b1);
    chk("buffered a", 16'h0222, cap_a);
    chk("buffered c", 16'h0111, cap_c);
    cnt = 16'h0333;
    pin(2, 1'b1);
    chk("c while buffered", 16'h0111, cap_c);
    rchk(8'ha0);
    buf_a = 1'b0;
    sel[2] = 1'b0;
    pin(2, 1'b0);
    chk("capture c", 16'h0333, cap_c);
    pin(1, 1'b1);
    chk("capture b", 16'h0333, cap_b);
    cnt = 16'h0444;
    buf_b = 1'b1;
    pin(1, 1'b0);
    pin(1, 1'b1);
    chk("buffered b", 16'h0444, cap_b);
    chk("buffered d", 16'h0333, cap_d);
    pin(3, 1'b1);
    chk("d while buffered", 16'h0333, cap_d);
    buf_b = 1'b0;
    cnt = 16'h0555;
    pin(3, 1'b0);
    pin(3, 1'b1);
    chk("capture d", 16'h0555, cap_d);
    rchk(8'hf0);
    irq_en = 7'b1111111;
    #1 chk("capture requests", 16'h0078, {9'h000, irq_req});
    $display("test capture done");
  endtask

  // falling selects, and buffered capture on both edges when the selects differ.
  task automatic t_edges;
    sel = 4'h0;
    cnt = 16'h0666;
    pin(0, 1'b0);
    chk("falling a", 16'h0666, cap_a);
    pin(1, 1'b0);
    chk("falling b", 16'h0666, cap_b);
    cnt = 16'h0676;
    pin(3, 1'b0);
    chk("falling d", 16'h0676, cap_d);
    buf_a = 1'b1;
    sel[0] = 1'b1;
    cnt = 16'h0777;
    pin(0, 1'b1);
    cnt = 16'h0888;
    pin(0, 1'b0);
    chk("both edges a", 16'h0888, cap_a);
    chk("both edges c", 16'h0777, cap_c);
    buf_b = 1'b1;
    sel[3] = 1'b1;
    cnt = 16'h0999;
    pin(1, 1'b1);
    chk("buffered b other select", 16'h0999, cap_b);
    chk("buffered d other select", 16'h0666, cap_d);
    buf_a = 1'b0;
    buf_b = 1'b0;
    cpu.clr(8'h00);
    rchk(8'h00);
    #1 chk("requests cleared", 16'h0000, {9'h000, irq_req});
    $display("test edges done");
  endtask

  task automatic t_standby;
    cpu.wr(8'h01);
    @(negedge clk_sys);
    standby_enter = 1'b1;
    repeat (2) @(negedge clk_sys);
    standby_enter = 1'b0;
    rchk(8'h00);
    chk("standby control", 16'h0000, {15'h0000, clr_lvl});
    chk("standby capture", 16'h0000, cap_a);
    $display("test standby done");
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The tests take well under a thousand cycles; twenty thousand means a hang.
  initial begin
    #(25 * 20000);
    n_fail++;
    end_sim();
  end

  // Main sequence: all inputs set at time zero, reset held for 16 cycles.
  initial begin
    n_fail = 0;
    tests_run = 0;
    reset = 1'b1;
    standby_enter = 1'b0;
    cnt = 16'h0100;
    cmp_a = 16'h1000;
    cmp_b = 16'h2000;
    pins = 4'h0;
    sel = 4'hf;
    buf_a = 1'b0;
    buf_b = 1'b0;
    irq_en = 7'b0000000;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_wrap();
    t_compare();
    t_capture();
    t_edges();
    t_standby();
    end_sim();
  end
endmodule
